// ---- logic/ptd_top.sv ----
// Purpose: pulse mode tap, double tap and freefall detector
// Assumes: sample_tick marks one detection sample; axis data valid then
// Notes: level comparison lives elsewhere and arrives as level_hit
// Summary of operation
// (RULE1) polarity picks any-over or all-under compare
// (RULE2) single pulse must end within duration
// (RULE3) freefall needs all below beyond latency
// (RULE4) double: pulse, latency gap, second pulse
// (RULE5) zero second window means single only
// (RULE6) events drive their assigned interrupt line
// (RULE7) source register shows detection outcome
// (RULE8) route 00: level first, pulse second
// (RULE9) route 01: pulse first, level second
// (RULE10) route 10: single first, single/double second
// (RULE11) only three routing codes are defined
// (RULE12) pin swap crosses lines and status bits; code swaps the lines only, status bits stay put
// (RULE13) route 10: line b clear clears both
// (RULE14) duration register resets to one
// (RULE15) latency register resets to one
// (RULE16) threshold and second window reset zero
// (RULE17) detection runs only in mode 11
// (RULE18) line stays until clear; zero re-arms
// (RULE19) axes enabled; disable bit excludes axis
// (RULE20) windows counted in sample ticks
// (RULE21) route 11 behaves as route 00
`timescale 1ns/1ps
module ptd_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic sample_tick,
   input wire logic [7:0] axis_x,
   input wire logic [7:0] axis_y,
   input wire logic [7:0] axis_z,
   input wire logic level_hit,
   input wire logic [2:0] level_axis,
   output logic irq_line_a,
   output logic irq_line_b
);
   logic [7:0] mode_r;
   logic [7:0] clear_r;
   logic [7:0] ctrl_a_r;
   logic [7:0] ctrl_b_r;
   logic [7:0] thresh_r;
   logic [7:0] duration_r;
   logic [7:0] latency_r;
   logic [7:0] window2_r;
   logic [1:0] int_bit_r;
   logic [1:0] int_bit_nxt;
   logic [2:0] pulse_axis_r;
   logic [2:0] level_axis_r;
   logic [8:0] cnt_r;
   logic [8:0] cnt_nxt;
   logic [7:0] rdata_r;
   logic rvalid_r;
   logic line_a_r;
   logic line_b_r;
   ptd_pkg::ptd_state_t state_r;
   ptd_pkg::ptd_state_t state_nxt;

   // register write decode
   wire wr_mode = reg_wr_en && reg_addr == ptd_pkg::ADDR_MODE;
   wire wr_clear = reg_wr_en && reg_addr == ptd_pkg::ADDR_CLEAR;
   wire wr_ctrl_a = reg_wr_en && reg_addr == ptd_pkg::ADDR_CTRL_A;
   wire wr_ctrl_b = reg_wr_en && reg_addr == ptd_pkg::ADDR_CTRL_B;
   wire wr_thresh = reg_wr_en && reg_addr == ptd_pkg::ADDR_THRESH;
   wire wr_dur = reg_wr_en && reg_addr == ptd_pkg::ADDR_DURATION;
   wire wr_lat = reg_wr_en && reg_addr == ptd_pkg::ADDR_LATENCY;
   wire wr_win2 = reg_wr_en && reg_addr == ptd_pkg::ADDR_WINDOW2;

   // control fields
   wire pin_swap = ctrl_a_r[ptd_pkg::CA_PIN_SWAP];
   wire [1:0] route_sel = ctrl_a_r[ptd_pkg::CA_ROUTE_LO +: 2];
   wire [2:0] axis_off = ctrl_a_r[ptd_pkg::CA_X_OFF +: 3];
   wire sign_opt = ctrl_a_r[ptd_pkg::CA_SIGN_OPT];
   wire pulse_pol = ctrl_b_r[ptd_pkg::CB_PULSE_POL];
   wire clr_a = clear_r[ptd_pkg::CL_LINE_A];
   wire clr_b = clear_r[ptd_pkg::CL_LINE_B];
   // (RULE17) pulse mode gate
   wire pulse_mode = mode_r[1:0] == ptd_pkg::MODE_PULSE;
   // (RULE5) double pulse enable
   wire dbl_en = window2_r != 8'h00;
   wire dbl_only = dbl_en && latency_r != 8'h00;

   // per-axis threshold compare
   wire [7:0] axis_v [3];
   assign axis_v[0] = axis_x;
   assign axis_v[1] = axis_y;
   assign axis_v[2] = axis_z;
   wire [2:0] over;
   wire [2:0] under;
   wire [8:0] th_abs = {2'h0, thresh_r[6:0]};
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_axis
         wire [8:0] ext = {axis_v[gi][7], axis_v[gi]};
         wire [8:0] mag = axis_v[gi][7] ? (9'h000 - ext) : ext;
         wire s_over = $signed(axis_v[gi]) > $signed(thresh_r);
         wire s_under = $signed(axis_v[gi]) < $signed(thresh_r);
         assign over[gi] = sign_opt ? s_over : (mag > th_abs);
         assign under[gi] = sign_opt ? s_under : (mag < th_abs);
      end
   endgenerate

   // (RULE19) disabled axes drop out
   wire [2:0] axis_en = ~axis_off;
   wire any_over = |(over & axis_en);
   wire all_under = (&(under | axis_off)) && (axis_en != 3'h0);
   // (RULE1) polarity selects compare
   wire hit = pulse_pol ? all_under : any_over;
   wire tick_hit = sample_tick && hit;

   // (RULE13) shared clear in route 10
   wire route_sd = route_sel == ptd_pkg::ROUTE_SGL_DBL;
   wire restart = route_sd && clr_b;

   // sequence counters, widened so cnt can exceed a full 255 window
   wire [8:0] cnt_inc = cnt_r + 9'h001;
   wire [8:0] dur9 = {1'b0, duration_r};
   wire [8:0] lat9 = {1'b0, latency_r};
   wire [8:0] win9 = {1'b0, window2_r};

   logic single_evt;
   logic double_evt;
   logic fall_evt;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      single_evt = 1'b0;
      double_evt = 1'b0;
      fall_evt = 1'b0;
      if (!pulse_mode || restart) begin
         state_nxt = ptd_pkg::PTD_IDLE;
         cnt_nxt = 9'h000;
      end else if (sample_tick) begin
         // (RULE20) one count per tick
         case (state_r)
            ptd_pkg::PTD_IDLE: begin
               cnt_nxt = 9'h001;
               if (hit && pulse_pol) begin
                  state_nxt = ptd_pkg::PTD_FALL;
               end else if (hit) begin
                  state_nxt = ptd_pkg::PTD_FIRST;
               end
            end
            ptd_pkg::PTD_FIRST: begin
               // (RULE2) pulse ends inside duration
               if (!hit) begin
                  single_evt = 1'b1;
                  cnt_nxt = 9'h000;
                  state_nxt = dbl_en ? ptd_pkg::PTD_LAT : ptd_pkg::PTD_IDLE;
               end else if (cnt_r >= dur9) begin
                  state_nxt = ptd_pkg::PTD_REJECT;
               end else begin
                  cnt_nxt = cnt_inc;
               end
            end
            ptd_pkg::PTD_LAT: begin
               // (RULE4) latency gap ignores input
               if (cnt_inc >= lat9) begin
                  cnt_nxt = 9'h000;
                  state_nxt = ptd_pkg::PTD_WIN2;
               end else begin
                  cnt_nxt = cnt_inc;
               end
            end
            ptd_pkg::PTD_WIN2: begin
               // (RULE4) second pulse must start in window
               if (hit) begin
                  cnt_nxt = 9'h001;
                  state_nxt = ptd_pkg::PTD_SECOND;
               end else if (cnt_inc >= win9) begin
                  cnt_nxt = 9'h000;
                  state_nxt = ptd_pkg::PTD_IDLE;
               end else begin
                  cnt_nxt = cnt_inc;
               end
            end
            ptd_pkg::PTD_SECOND: begin
               if (!hit) begin
                  double_evt = 1'b1;
                  cnt_nxt = 9'h000;
                  state_nxt = ptd_pkg::PTD_IDLE;
               end else if (cnt_r >= dur9) begin
                  state_nxt = ptd_pkg::PTD_REJECT;
               end else begin
                  cnt_nxt = cnt_inc;
               end
            end
            ptd_pkg::PTD_FALL: begin
               // (RULE3) all below longer than latency
               if (!hit) begin
                  cnt_nxt = 9'h000;
                  state_nxt = ptd_pkg::PTD_IDLE;
               end else if (cnt_r > lat9) begin
                  fall_evt = 1'b1;
                  state_nxt = ptd_pkg::PTD_REJECT;
               end else begin
                  cnt_nxt = cnt_inc;
               end
            end
            ptd_pkg::PTD_REJECT: begin
               // a too-long pulse must fall away before rearming
               cnt_nxt = 9'h000;
               if (!hit) begin
                  state_nxt = ptd_pkg::PTD_IDLE;
               end
            end
            default: begin
               cnt_nxt = 9'h000;
               state_nxt = ptd_pkg::PTD_IDLE;
            end
         endcase
      end
   end

   // pulse detection as seen by routes 00 and 01
   wire pulse_evt = (dbl_en ? double_evt : single_evt) || fall_evt;
   wire level_evt = level_hit;
   wire sd_bit1 = single_evt || fall_evt;
   wire sd_bit2 = (dbl_only ? double_evt : single_evt) || fall_evt;

   // (RULE8) (RULE9) (RULE11) (RULE21) routing select
   logic [1:0] route_set;
   always_comb begin
      case (route_sel)
         ptd_pkg::ROUTE_PLS_LVL: route_set = {level_evt, pulse_evt};
         // (RULE10) single and double pulse split
         ptd_pkg::ROUTE_SGL_DBL: route_set = {sd_bit2, sd_bit1};
         default: route_set = {pulse_evt, level_evt};
      endcase
   end

   // (RULE18) a held clear keeps the bit disarmed
   wire arm_a = route_sd ? !clr_b : !clr_a;
   wire arm_b = !clr_b;

   // (RULE6) events latch their interrupt bit
   always_comb begin
      int_bit_nxt = int_bit_r;
      if (!arm_a) begin
         int_bit_nxt[0] = 1'b0;
      end else if (route_set[0]) begin
         int_bit_nxt[0] = 1'b1;
      end
      if (!arm_b) begin
         int_bit_nxt[1] = 1'b0;
      end else if (route_set[1]) begin
         int_bit_nxt[1] = 1'b1;
      end
   end

   // first pulse axes, captured as the first pulse begins
   wire pulse_start = pulse_mode && !pulse_pol && tick_hit &&
                      state_r == ptd_pkg::PTD_IDLE;
   wire clr_any = clr_a || clr_b;

   // (RULE7) source register contents
   wire [7:0] source_val = {level_axis_r, pulse_axis_r, int_bit_r};

   // (RULE12) pin swap
   wire pin_a_nxt = pin_swap ? int_bit_nxt[1] : int_bit_nxt[0];
   wire pin_b_nxt = pin_swap ? int_bit_nxt[0] : int_bit_nxt[1];

   // read mux; unmapped offsets read as zero
   logic [7:0] rd_mux;
   always_comb begin
      case (reg_addr)
         ptd_pkg::ADDR_SOURCE: rd_mux = source_val;
         ptd_pkg::ADDR_MODE: rd_mux = mode_r;
         ptd_pkg::ADDR_CLEAR: rd_mux = clear_r;
         ptd_pkg::ADDR_CTRL_A: rd_mux = ctrl_a_r;
         ptd_pkg::ADDR_CTRL_B: rd_mux = ctrl_b_r;
         ptd_pkg::ADDR_THRESH: rd_mux = thresh_r;
         ptd_pkg::ADDR_DURATION: rd_mux = duration_r;
         ptd_pkg::ADDR_LATENCY: rd_mux = latency_r;
         ptd_pkg::ADDR_WINDOW2: rd_mux = window2_r;
         default: rd_mux = 8'h00;
      endcase
   end

   // (RULE14) (RULE15) (RULE16) register reset values
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_r <= ptd_pkg::RST_MODE;
         clear_r <= ptd_pkg::RST_CLEAR;
         ctrl_a_r <= ptd_pkg::RST_CTRL_A;
         ctrl_b_r <= ptd_pkg::RST_CTRL_B;
         thresh_r <= ptd_pkg::RST_THRESH;
         duration_r <= ptd_pkg::RST_DURATION;
         latency_r <= ptd_pkg::RST_LATENCY;
         window2_r <= ptd_pkg::RST_WINDOW2;
      end else begin
         if (wr_mode) mode_r <= reg_wdata;
         if (wr_clear) clear_r <= reg_wdata & 8'h03;
         if (wr_ctrl_a) ctrl_a_r <= reg_wdata;
         if (wr_ctrl_b) ctrl_b_r <= reg_wdata & 8'h07;
         if (wr_thresh) thresh_r <= reg_wdata;
         if (wr_dur) duration_r <= reg_wdata;
         if (wr_lat) latency_r <= reg_wdata;
         if (wr_win2) window2_r <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ptd_pkg::PTD_IDLE;
         cnt_r <= 9'h000;
         int_bit_r <= 2'h0;
         line_a_r <= 1'b0;
         line_b_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         int_bit_r <= int_bit_nxt;
         line_a_r <= pin_a_nxt;
         line_b_r <= pin_b_nxt;
      end
   end

   // axis flags: new detection sets them, any clear bit wipes them
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pulse_axis_r <= 3'h0;
         level_axis_r <= 3'h0;
      end else begin
         if (pulse_start) begin
            pulse_axis_r <= {over[0], over[1], over[2]} & 
                            {axis_en[0], axis_en[1], axis_en[2]};
         end else if (clr_any) begin
            pulse_axis_r <= 3'h0;
         end
         if (level_hit) begin
            level_axis_r <= level_axis_r | level_axis;
         end else if (clr_any) begin
            level_axis_r <= 3'h0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_rd_en;
         if (reg_rd_en) rdata_r <= rd_mux;
      end
   end

   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign irq_line_a = line_a_r;
   assign irq_line_b = line_b_r;
endmodule

// ---- pkg/ptd_pkg.sv ----
// Purpose: constants shared by the pulse tap detector
// Assumes: 8-bit registers at their byte offsets
// Notes: field positions are bit indices inside each register
package ptd_pkg;
   // register offsets
   localparam logic [7:0] ADDR_SOURCE = 8'h0A;
   localparam logic [7:0] ADDR_MODE = 8'h16;
   localparam logic [7:0] ADDR_CLEAR = 8'h17;
   localparam logic [7:0] ADDR_CTRL_A = 8'h18;
   localparam logic [7:0] ADDR_CTRL_B = 8'h19;
   localparam logic [7:0] ADDR_THRESH = 8'h1B;
   localparam logic [7:0] ADDR_DURATION = 8'h1C;
   localparam logic [7:0] ADDR_LATENCY = 8'h1D;
   localparam logic [7:0] ADDR_WINDOW2 = 8'h1E;
   // reset values
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_CLEAR = 8'h00;
   localparam logic [7:0] RST_CTRL_A = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_THRESH = 8'h00;
   localparam logic [7:0] RST_DURATION = 8'h01;
   localparam logic [7:0] RST_LATENCY = 8'h01;
   localparam logic [7:0] RST_WINDOW2 = 8'h00;
   // control a fields
   localparam int CA_PIN_SWAP = 0;
   localparam int CA_ROUTE_LO = 1;
   localparam int CA_X_OFF = 3;
   localparam int CA_SIGN_OPT = 6;
   localparam int CA_FILTER_BW = 7;
   // control b fields
   localparam int CB_LEVEL_POL = 0;
   localparam int CB_PULSE_POL = 1;
   localparam int CB_DRIVE_OPT = 2;
   // clear register fields
   localparam int CL_LINE_A = 0;
   localparam int CL_LINE_B = 1;
   // source register fields
   localparam int SR_INT_LO = 0;
   localparam int SR_PULSE_LO = 2;
   localparam int SR_LEVEL_LO = 5;
   // operating modes and routing codes
   localparam logic [1:0] MODE_PULSE = 2'h3;
   localparam logic [1:0] ROUTE_LVL_PLS = 2'h0;
   localparam logic [1:0] ROUTE_PLS_LVL = 2'h1;
   localparam logic [1:0] ROUTE_SGL_DBL = 2'h2;
   typedef enum logic [2:0] {
      PTD_IDLE = 3'h0,
      PTD_FIRST = 3'h1,
      PTD_LAT = 3'h3,
      PTD_WIN2 = 3'h2,
      PTD_SECOND = 3'h6,
      PTD_REJECT = 3'h7,
      PTD_FALL = 3'h5
   } ptd_state_t;
endpackage

// ---- bench/ptd_assertions.sv ----
// Purpose: port-level checks for the pulse tap detector
// Assumes: one clock, asynchronous active-low reset
// Notes: pin swap is tracked from control a writes
`timescale 1ns/1ps
module ptd_assertions (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic sample_tick,
   input wire logic level_hit,
   input wire logic irq_line_a,
   input wire logic irq_line_b
);
   logic swap_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         swap_r <= 1'b0;
      end else if (reg_wr_en && reg_addr == ptd_pkg::ADDR_CTRL_A) begin
         swap_r <= reg_wdata[ptd_pkg::CA_PIN_SWAP];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   a_read_answer: assert property (
      reg_rd_en |=> reg_rvalid)
      else $error("read not answered next cycle");
   a_answer_cause: assert property (
      reg_rvalid |-> $past(reg_rd_en))
      else $error("read answer without request");
   a_rdata_holds: assert property (
      !reg_rvalid |-> $stable(reg_rdata))
      else $error("read data moved without answer");
   a_ctrlb_unused: assert property (
      reg_rd_en && reg_addr == ptd_pkg::ADDR_CTRL_B
      |=> reg_rdata[7:3] == 5'h00)
      else $error("control b unused bits not zero");
   a_line_a_clear: assert property (
      $fell(irq_line_a) |-> $past(reg_wr_en, 2)
      && $past(reg_addr, 2) == ptd_pkg::ADDR_CLEAR)
      else $error("line a dropped without clear");
   a_line_b_clear: assert property (
      $fell(irq_line_b) |-> $past(reg_wr_en, 2)
      && $past(reg_addr, 2) == ptd_pkg::ADDR_CLEAR)
      else $error("line b dropped without clear");
   a_line_a_tick: assert property (
      $rose(irq_line_a) && !$past(level_hit) |-> $past(sample_tick))
      else $error("line a rose off a sample tick");
   a_line_b_tick: assert property (
      $rose(irq_line_b) && !$past(level_hit) |-> $past(sample_tick))
      else $error("line b rose off a sample tick");
   a_source_pins: assert property (
      reg_rd_en && reg_addr == ptd_pkg::ADDR_SOURCE |=> reg_rdata[1:0]
      == (swap_r ? {$past(irq_line_a), $past(irq_line_b)}
      : {$past(irq_line_b), $past(irq_line_a)}))
      else $error("source bits disagree with pins");
endmodule
bind ptd_top ptd_assertions chk_u (.clk(clk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
   .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .sample_tick(sample_tick),
   .level_hit(level_hit), .irq_line_a(irq_line_a),
   .irq_line_b(irq_line_b));

// ---- bench/tb.sv ----
// Purpose: register-driven test of the pulse tap detector
// Assumes: axes rest at zero unless a scenario drives them
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
module tb;
   logic clk, rst_b, wr_en, rd_en, tick, lvl, rvalid, irq_a, irq_b;
   logic [7:0] addr, wdata, rdata, ax, ay, az;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   ptd_top dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(addr),
      .reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rd_en(rd_en),
      .reg_rdata(rdata), .reg_rvalid(rvalid), .sample_tick(tick),
      .axis_x(ax), .axis_y(ay), .axis_z(az), .level_hit(lvl),
      .level_axis(3'h4), .irq_line_a(irq_a), .irq_line_b(irq_b));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic test_done();
      if (n_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // a hang shows up as a mismatch, not a silent stall
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         test_done();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      chk(rdata, e);
   endtask
   task automatic tk3(input logic [7:0] x, input logic [7:0] y,
      input logic [7:0] z);
      @(negedge clk);
      ax = x;
      ay = y;
      az = z;
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
   endtask
   task automatic tk(input logic [7:0] x);
      tk3(x, 8'h00, 8'h00);
   endtask
   task automatic lv();
      @(negedge clk);
      lvl = 1'b1;
      repeat (2) @(negedge clk);
      lvl = 1'b0;
   endtask
   task automatic ck_irq(input logic [1:0] e);
      repeat (2) @(negedge clk);
      chk({6'h00, irq_b, irq_a}, {6'h00, e});
   endtask
   task automatic clr(input logic [7:0] v, input logic [1:0] e);
      wr(ptd_pkg::ADDR_CLEAR, v);
      ck_irq(e);
      wr(ptd_pkg::ADDR_CLEAR, 8'h00);
   endtask
   initial begin
      rst_b = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      tick = 1'b0;
      ax = 8'h00;
      ay = 8'h00;
      az = 8'h00;
      lvl = 1'b0;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      rd(ptd_pkg::ADDR_DURATION, 8'h01);
      rd(ptd_pkg::ADDR_LATENCY, 8'h01);
      rd(ptd_pkg::ADDR_THRESH, 8'h00);
      rd(ptd_pkg::ADDR_WINDOW2, 8'h00);
      rd(ptd_pkg::ADDR_CTRL_A, 8'h00);
      wr(ptd_pkg::ADDR_SOURCE, 8'hFF);
      rd(ptd_pkg::ADDR_SOURCE, 8'h00);
      wr(ptd_pkg::ADDR_CTRL_B, 8'hFF);
      rd(ptd_pkg::ADDR_CTRL_B, 8'h07);
      wr(ptd_pkg::ADDR_CTRL_B, 8'h00);
      rd(8'h00, 8'h00);
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b00);
      wr(ptd_pkg::ADDR_THRESH, 8'h10);
      wr(ptd_pkg::ADDR_MODE, {6'h00, ptd_pkg::MODE_PULSE});
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b10);
      rd(ptd_pkg::ADDR_SOURCE, 8'h12);
      wr(ptd_pkg::ADDR_CLEAR, 8'h02);
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b00);
      wr(ptd_pkg::ADDR_CLEAR, 8'h00);
      tk(8'h20);
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b00);
      wr(ptd_pkg::ADDR_DURATION, 8'h02);
      tk(8'h20);
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b10);
      clr(8'h02, 2'b00);
      wr(ptd_pkg::ADDR_CTRL_A, 8'h01);
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b01);
      rd(ptd_pkg::ADDR_SOURCE, 8'h12);
      lv();
      ck_irq(2'b11);
      rd(ptd_pkg::ADDR_SOURCE, 8'h93);
      clr(8'h03, 2'b00);
      wr(ptd_pkg::ADDR_CTRL_A, 8'h02);
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b01);
      lv();
      ck_irq(2'b11);
      clr(8'h03, 2'b00);
      wr(ptd_pkg::ADDR_CTRL_A, 8'h06);
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b10);
      clr(8'h02, 2'b00);
      wr(ptd_pkg::ADDR_CTRL_A, 8'h08);
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b00);
      tk3(8'h00, 8'h20, 8'h00);
      tk(8'h00);
      ck_irq(2'b10);
      rd(ptd_pkg::ADDR_SOURCE, 8'h0A);
      clr(8'h02, 2'b00);
      wr(ptd_pkg::ADDR_CTRL_A, 8'h04);
      wr(ptd_pkg::ADDR_WINDOW2, 8'h03);
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b01);
      tk(8'h00);
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b11);
      clr(8'h01, 2'b11);
      clr(8'h02, 2'b00);
      // a clear that fails to restart would turn the pulse after the next clear into a double
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b01);
      clr(8'h02, 2'b00);
      tk(8'h00);
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b01);
      clr(8'h02, 2'b00);
      wr(ptd_pkg::ADDR_WINDOW2, 8'h00);
      tk(8'h20);
      tk(8'h00);
      ck_irq(2'b11);
      clr(8'h02, 2'b00);
      wr(ptd_pkg::ADDR_CTRL_A, 8'h00);
      wr(ptd_pkg::ADDR_CTRL_B, 8'h02);
      tk(8'h00);
      tk(8'h00);
      ck_irq(2'b00);
      tk(8'h00);
      ck_irq(2'b10);
      clr(8'h02, 2'b00);
      tk(8'h20);
      tk3(8'h00, 8'h00, 8'h20);
      tk3(8'h00, 8'h00, 8'h20);
      tk3(8'h00, 8'h00, 8'h20);
      ck_irq(2'b00);
      test_done();
   end
endmodule
